//--- hdl/reducer_defines.vh
// register map, field positions and reset values of the reducer window bank
`ifndef REDUCER_DEFINES_VH
`define REDUCER_DEFINES_VH
// register indexes; byte address is four times the index
`define IDX_B_H_OUT 12'h1A1
`define IDX_B_V_PAN 12'h1A2
`define IDX_B_V_WIN 12'h1A3
`define IDX_B_V_OUT 12'h1A4
`define IDX_A_H_PAN 12'h1A5
`define IDX_A_H_WIN 12'h1A6
`define IDX_A_H_OUT 12'h1A7
`define IDX_A_V_PAN 12'h1A8
`define IDX_A_V_WIN 12'h1A9
`define IDX_A_V_OUT 12'h1AA
`define IDX_LIVE_H_WIN 12'h1AB
// own additions: context select and live zoom load
`define IDX_CTX_SEL 12'h1B0
`define IDX_ZOOM_CTL 12'h1B1
// field positions
`define ORIGIN_BIT 14
`define FIELD_MSB 10
`define PAN_MASK 16'h47FF
`define SIZE_MASK 16'h07FF
// reset values
`define RST_PAN 16'h0000
`define RST_B_H_OUT 16'h0500
`define RST_B_V_WIN 16'h0400
`define RST_B_V_OUT 16'h0400
`define RST_A_H_WIN 16'h0500
`define RST_A_H_OUT 16'h0280
`define RST_A_V_WIN 16'h0400
`define RST_A_V_OUT 16'h0200
`define RST_B_H_WIN 16'h0500
`define RST_B_H_PAN 16'h0000
// centred origins
`define CENTRE_COL 12'h280
`define CENTRE_ROW 12'h200
`endif

//--- hdl/pan_origin.v
// resolves a pan register into an absolute start coordinate
`timescale 1ns/1ps
`default_nettype none
`include "reducer_defines.vh"
module pan_origin #(
   parameter [11:0] CENTRE = 12'h200
) (
   input wire [15:0] pan,
   output wire [11:0] start
);
   // sign-extend the field; centred mode adds two's complement offset
   wire [11:0] offset_ext;
   assign offset_ext = {pan[`FIELD_MSB], pan[`FIELD_MSB:0]};
   assign start = pan[`ORIGIN_BIT] ? CENTRE + offset_ext
                                    : {1'b0, pan[`FIELD_MSB:0]};
endmodule // pan_origin
`default_nettype wire

//--- hdl/reducer_window_config.v
// apb register bank for the reducer zoom window, pan and output size
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "reducer_defines.vh"
// Summary of operation
// - context B vertical pan bit 14 picks top row or centred row 512
// - B vertical pan: unsigned from row 0, or signed from row 512
// - context B zoom height resets to 0x0400
// - B output height resets 0x0400, B output width resets 0x0500
// - context A horizontal pan bit 14 picks column 0 or 640; resets zero
// - A horizontal pan: unsigned from column 0, or signed from 640
// - context A zoom width resets to 0x0500
// - context A output width resets to 0x0280
// - A vertical pan bit 14 picks row 0 or signed from row 512
// - A zoom height resets 0x0400, A output height resets 0x0200
// - live zoom width register is read-only, writes ignored
// - live width in bits 10:0, tracks automatic zoom, 15:11 reserved
module reducer_window_config (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg ctx_sel_b,
   output reg [11:0] win_col_start,
   output reg [11:0] win_row_start,
   output reg [10:0] win_width,
   output reg [10:0] win_height,
   output reg [10:0] out_width,
   output reg [10:0] out_rows
);
   reg [15:0] b_h_out, b_v_pan, b_v_win, b_v_out;
   reg [15:0] a_h_pan, a_h_win, a_h_out, a_v_pan, a_v_win, a_v_ext;
   reg [10:0] live_width;
   reg ctx_sel;
   wire [11:0] idx;
   wire access;
   wire wr;
   reg [31:0] next_prdata;
   reg hit;
   wire [11:0] a_col, b_col, a_row, b_row;
   // context B zoom width is not held here; its reset value stands in
   wire [15:0] b_h_win_rst;

   assign b_h_win_rst = `RST_B_H_WIN;

   assign idx = paddr[13:2];
   // slave answers one cycle after the first access cycle, one wait state
   assign access = psel & penable & ~pready;
   assign wr = access & pwrite & (paddr[1:0] == 2'b00) & hit;

   // read mux; unmapped offsets answer with an error
   always @* begin
      next_prdata = 32'h0000_0000;
      hit = 1'b1;
      case (idx)
         `IDX_B_H_OUT: next_prdata = {16'h0000, b_h_out};
         `IDX_B_V_PAN: next_prdata = {16'h0000, b_v_pan};
         `IDX_B_V_WIN: next_prdata = {16'h0000, b_v_win};
         `IDX_B_V_OUT: next_prdata = {16'h0000, b_v_out};
         `IDX_A_H_PAN: next_prdata = {16'h0000, a_h_pan};
         `IDX_A_H_WIN: next_prdata = {16'h0000, a_h_win};
         `IDX_A_H_OUT: next_prdata = {16'h0000, a_h_out};
         `IDX_A_V_PAN: next_prdata = {16'h0000, a_v_pan};
         `IDX_A_V_WIN: next_prdata = {16'h0000, a_v_win};
         `IDX_A_V_OUT: next_prdata = {16'h0000, a_v_ext};
         `IDX_LIVE_H_WIN: next_prdata = {21'h0, live_width};
         `IDX_CTX_SEL: next_prdata = {31'h00000000, ctx_sel};
         `IDX_ZOOM_CTL: next_prdata = 32'h0000_0000;
         default: hit = 1'b0;
      endcase
      // upper address bits must be zero, else the bank would alias
      if (paddr[31:14] != 18'h0)
         hit = 1'b0;
   end

   // apb handshake and read data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= access & (~hit | (paddr[1:0] != 2'b00));
         if (access & ~pwrite)
            prdata <= hit ? next_prdata : 32'h0000_0000;
      end
   end

   // register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_h_out <= `RST_B_H_OUT;
         b_v_out <= `RST_B_V_OUT;
         b_v_win <= `RST_B_V_WIN;
         b_v_pan <= `RST_PAN;
         a_h_pan <= `RST_PAN;
         a_h_win <= `RST_A_H_WIN;
         a_h_out <= `RST_A_H_OUT;
         a_v_pan <= `RST_PAN;
         a_v_win <= `RST_A_V_WIN;
         a_v_ext <= `RST_A_V_OUT;
         ctx_sel <= 1'b0;
      end else if (wr) begin
         // 16-bit fields, undefined bits held zero
         case (idx)
            `IDX_B_H_OUT: b_h_out <= pwdata[15:0] & `SIZE_MASK;
            `IDX_B_V_PAN: b_v_pan <= pwdata[15:0] & `PAN_MASK;
            `IDX_B_V_WIN: b_v_win <= pwdata[15:0] & `SIZE_MASK;
            `IDX_B_V_OUT: b_v_out <= pwdata[15:0] & `SIZE_MASK;
            `IDX_A_H_PAN: a_h_pan <= pwdata[15:0] & `PAN_MASK;
            `IDX_A_H_WIN: a_h_win <= pwdata[15:0] & `SIZE_MASK;
            `IDX_A_H_OUT: a_h_out <= pwdata[15:0] & `SIZE_MASK;
            `IDX_A_V_PAN: a_v_pan <= pwdata[15:0] & `PAN_MASK;
            `IDX_A_V_WIN: a_v_win <= pwdata[15:0] & `SIZE_MASK;
            `IDX_A_V_OUT: a_v_ext <= pwdata[15:0] & `SIZE_MASK;
            `IDX_CTX_SEL: ctx_sel <= pwdata[0];
            default: ctx_sel <= ctx_sel;
         endcase
      end
   end

   // live zoom width: loaded from the active context window, or by
   // a write to the zoom control word (stand-in for automatic zoom)
   // writes to the live register itself are ignored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         live_width <= 11'h500;
      else if (wr && idx == `IDX_ZOOM_CTL)
         live_width <= pwdata[10:0];
      else if (wr && (idx == `IDX_A_H_WIN) && !ctx_sel)
         live_width <= pwdata[10:0];
      else if (wr && idx == `IDX_CTX_SEL)
         live_width <= pwdata[0] ? b_h_win_rst[10:0] : a_h_win[10:0];
   end

   // context A column start, signed from 640 in centred mode
   pan_origin #(.CENTRE(`CENTRE_COL)) u_a_col (
      .pan(a_h_pan),
      .start(a_col)
   );
   pan_origin #(.CENTRE(`CENTRE_ROW)) u_a_row (
      .pan(a_v_pan),
      .start(a_row)
   );
   pan_origin #(.CENTRE(`CENTRE_ROW)) u_b_row (
      .pan(b_v_pan),
      .start(b_row)
   );
   // context B horizontal pan lives outside this bank; fixed at reset
   pan_origin #(.CENTRE(`CENTRE_COL)) u_b_col (
      .pan(`RST_B_H_PAN),
      .start(b_col)
   );

   // window outputs follow the active context, except width, taken from the live zoom width
   // bit 14 of B vertical pan chose origin via pan_origin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctx_sel_b <= 1'b0;
         win_col_start <= 12'h000;
         win_row_start <= 12'h000;
         win_width <= 11'h500;
         win_height <= 11'h400;
         out_width <= 11'h280;
         out_rows <= 11'h200;
      end else begin
         ctx_sel_b <= ctx_sel;
         win_col_start <= ctx_sel ? b_col : a_col;
         win_row_start <= ctx_sel ? b_row : a_row;
         win_width <= live_width;
         win_height <= ctx_sel ? b_v_win[10:0] : a_v_win[10:0];
         out_width <= ctx_sel ? b_h_out[10:0] : a_h_out[10:0];
         out_rows <= ctx_sel ? b_v_out[10:0] : a_v_ext[10:0];
      end
   end
endmodule // reducer_window_config
`default_nettype wire

//--- verification/reducer_window_config_chk.sv
// assertion checker for the reducer window register bank
`timescale 1ns/1ps
`default_nettype none
module reducer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ctx_sel_b
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // first access cycle, where the bank takes the request
   sequence taken_s;
      psel && penable && !pready;
   endsequence
   sequence ctx_wr_s;
      taken_s ##0 (pwrite && paddr == 32'h0000_06C0) ##1 pready;
   endsequence
   ready_one_wait_a:
      assert property (taken_s |=> pready) else $error("ready late");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready too long");
   err_with_ready_a:
      assert property (pslverr |-> pready) else $error("stray error");
   ready_cause_a:
      assert property ($rose(pready) |-> $past(psel && penable))
      else $error("ready without request");
   // unmapped space and unaligned words are refused
   refused_a:
      assert property (taken_s ##0 (paddr[31:14] != 0 || paddr[1:0] != 0)
         |=> pslverr && (pwrite || prdata == 32'h0)) else $error("no refusal");
   upper_zero_a:
      assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   live_ro_a:
      assert property (taken_s ##0 (pwrite && paddr == 32'h0000_06AC)
         |=> !pslverr) else $error("live write refused");
   live_reserved_a:
      assert property (pready && !pwrite && paddr == 32'h0000_06AC
         |-> prdata[15:11] == 5'h0) else $error("live reserved bits set");
   ctx_follow_a:
      assert property (ctx_wr_s |=> ##1 ctx_sel_b == $past(pwdata[0], 3))
      else $error("context select not taken");
endmodule // reducer_chk
`default_nettype wire

//--- verification/reducer_window_config_tb_top.sv
// self-checking bench for the reducer window register bank
`timescale 1ns/1ps
`default_nettype none
`include "reducer_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module reducer_window_config_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic pready, pslverr, ctx_sel_b, err;
   logic [11:0] win_col_start, win_row_start;
   logic [10:0] win_width, win_height, out_width, out_rows;
   int n_fail = 0, cmp_count = 0;
   reducer_window_config DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .ctx_sel_b,
      .win_col_start, .win_row_start, .win_width, .win_height, .out_width,
      .out_rows);
   // 200 MHz clock
   initial forever #2.5 pclk = ~pclk;
   function automatic [31:0] ba(input [11:0] i);
      ba = {18'h0, i, 2'b00};
   endfunction
   task end_of_test;
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer; the wait is bounded so a dead slave ends the run
   task xfer(input [31:0] a, input [31:0] d, input w);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin n_fail++; end_of_test(); end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdchk(input [11:0] i, input [15:0] e);
      xfer(ba(i), 32'h0, 0);
      `CHK(rd, {16'h0, e})
   endtask
   // outputs follow a write one edge after the answer
   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      #1 `CHK(out_rows, 11'h200)
      `CHK(out_width, 11'h280)
      `CHK(win_width, 11'h500)
      `CHK(win_height, 11'h400)
      rdchk(`IDX_B_H_OUT, 16'h0500);
      rdchk(`IDX_B_V_PAN, 16'h0000);
      rdchk(`IDX_B_V_WIN, 16'h0400);
      rdchk(`IDX_B_V_OUT, 16'h0400);
      rdchk(`IDX_A_H_PAN, 16'h0000);
      rdchk(`IDX_A_H_WIN, 16'h0500);
      rdchk(`IDX_A_V_WIN, 16'h0400);
      rdchk(`IDX_A_V_OUT, 16'h0200);
      rdchk(`IDX_LIVE_H_WIN, 16'h0500);
      xfer(ba(`IDX_A_H_PAN), 32'hFFFF_FFFF, 1);
      rdchk(`IDX_A_H_PAN, 16'h47FF);
      settle;
      `CHK(win_col_start, 12'h27F)
      xfer(ba(`IDX_A_H_PAN), 32'h5, 1);
      settle;
      `CHK(win_col_start, 12'h005)
      xfer(ba(`IDX_A_V_PAN), 32'h4005, 1);
      xfer(ba(`IDX_A_V_WIN), 32'hFFFF_FFFF, 1);
      xfer(ba(`IDX_A_V_OUT), 32'hFFFF_FFFF, 1);
      rdchk(`IDX_A_V_OUT, 16'h07FF);
      settle;
      `CHK(win_row_start, 12'h205)
      `CHK(out_rows, 11'h7FF)
      `CHK(win_height, 11'h7FF)
      xfer(ba(`IDX_LIVE_H_WIN), 32'h123, 1);
      `CHK(err, 1'b0)
      rdchk(`IDX_LIVE_H_WIN, 16'h0500);
      xfer(ba(`IDX_A_H_WIN), 32'h400, 1);
      rdchk(`IDX_LIVE_H_WIN, 16'h0400);
      `CHK(win_width, 11'h400)
      xfer(32'h0000_4000, 32'h0, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      xfer(ba(`IDX_A_H_OUT) + 32'h1, 32'h5, 1);
      `CHK(err, 1'b1)
      rdchk(`IDX_A_H_OUT, 16'h0280);
      xfer(ba(`IDX_CTX_SEL), 32'h1, 1);
      xfer(ba(`IDX_B_V_PAN), 32'h47FF, 1);
      settle;
      `CHK(ctx_sel_b, 1'b1)
      `CHK({out_rows, out_width}, {11'h400, 11'h500})
      `CHK(win_row_start, 12'h1FF)
      xfer(ba(`IDX_B_V_PAN), 32'h3, 1);
      settle;
      `CHK(win_row_start, 12'h003)
      xfer(ba(`IDX_ZOOM_CTL), 32'h333, 1);
      rdchk(`IDX_LIVE_H_WIN, 16'h0333);
      end_of_test();
   end
endmodule // reducer_window_config_tb_top
bind reducer_window_config reducer_chk chk_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .ctx_sel_b);
`default_nettype wire
